// ### hdl/set_flag_compare_unit.sv
// Set-flag compare unit: decodes the compare family, compares a source
// register with a second register or an extended immediate, and
// updates the compare flag of the supervision register.
// Assumes operand values arrive with the instruction in the same cycle
// and that the flag holder reads flag_o one cycle after issue.
`timescale 1ns/100ps
`include "sfc_map.svh"

module set_flag_compare_unit (
  input  wire logic                  mclk_i,
  input  wire logic                  srst_i,
  input  wire logic                  instr_valid_i,
  input  wire logic [`SFC_INSN_W-1:0] instr_i,
  input  wire logic [`SFC_XLEN-1:0]  left_source_gpr_i,
  input  wire logic [`SFC_XLEN-1:0]  right_source_gpr_i,
  input  wire logic                  sr_flag_load_i,
  input  wire logic                  sr_flag_val_i,
  output logic [`SFC_IDX_W-1:0]      left_idx_o,
  output logic [`SFC_IDX_W-1:0]      right_idx_o,
  output logic                       flag_o,
  output logic                       flag_wr_o,
  output logic                       not_cmp_o,
  output logic                       rsv_nz_o
);

  // ==========================================================
  // Instruction fields
  logic [`SFC_OPC_W-1:0] opcode;
  logic [`SFC_IMM_W-1:0] imm;
  logic [`SFC_RSV_W-1:0] rsv_bits;

  assign opcode   = instr_i[`SFC_OPC_HI:`SFC_OPC_LO];
  assign imm      = instr_i[`SFC_IMM_HI:`SFC_IMM_LO];
  assign rsv_bits = instr_i[`SFC_RSV_HI:`SFC_RSV_LO];

  // Index outputs let the register file be read in the issue cycle
  assign left_idx_o  = instr_i[`SFC_LEFT_HI:`SFC_LEFT_LO];
  assign right_idx_o = instr_i[`SFC_RIGHT_HI:`SFC_RIGHT_LO];

  // ==========================================================
  // Opcode decode
  sfc_pkg::cmp_op_s op;

  always_comb begin
    op           = '0;
    op.hit       = 1'b1;
    op.cond      = sfc_pkg::COND_EQ;
    op.is_signed = 1'b0;
    op.use_imm   = 1'b0;
    case (opcode)
      `SFC_OP_EQ: begin
        op.cond = sfc_pkg::COND_EQ;
      end
      `SFC_OP_GTU: begin
        op.cond = sfc_pkg::COND_GT;
      end
      `SFC_OP_GEU: begin
        op.cond = sfc_pkg::COND_GE;
      end
      `SFC_OP_LEU: begin
        op.cond = sfc_pkg::COND_LE;
      end
      `SFC_OP_GTS: begin
        op.cond      = sfc_pkg::COND_GT;
        op.is_signed = 1'b1;
      end
      `SFC_OP_GES: begin
        op.cond      = sfc_pkg::COND_GE;
        op.is_signed = 1'b1;
      end
      `SFC_OP_LES: begin
        op.cond      = sfc_pkg::COND_LE;
        op.is_signed = 1'b1;
      end
      // Equality ignores signedness, but the immediate still
      // sign-extends, which is what is_signed selects below
      `SFC_OP_EQI: begin
        op.cond      = sfc_pkg::COND_EQ;
        op.is_signed = 1'b1;
        op.use_imm   = 1'b1;
      end
      `SFC_OP_GTUI: begin
        op.cond    = sfc_pkg::COND_GT;
        op.use_imm = 1'b1;
      end
      `SFC_OP_GEUI: begin
        op.cond    = sfc_pkg::COND_GE;
        op.use_imm = 1'b1;
      end
      `SFC_OP_LEUI: begin
        op.cond    = sfc_pkg::COND_LE;
        op.use_imm = 1'b1;
      end
      `SFC_OP_GTSI: begin
        op.cond      = sfc_pkg::COND_GT;
        op.is_signed = 1'b1;
        op.use_imm   = 1'b1;
      end
      `SFC_OP_GESI: begin
        op.cond      = sfc_pkg::COND_GE;
        op.is_signed = 1'b1;
        op.use_imm   = 1'b1;
      end
      `SFC_OP_LESI: begin
        op.cond      = sfc_pkg::COND_LE;
        op.is_signed = 1'b1;
        op.use_imm   = 1'b1;
      end
      default: begin
        op.hit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Immediate extension to full register width
  logic [`SFC_XLEN-1:0] imm_sext;
  logic [`SFC_XLEN-1:0] imm_zext;
  logic [`SFC_XLEN-1:0] rhs;

  assign imm_sext = {{(`SFC_XLEN-`SFC_IMM_W){imm[`SFC_IMM_W-1]}}, imm};
  assign imm_zext = {{(`SFC_XLEN-`SFC_IMM_W){1'b0}}, imm};

  always_comb begin
    if (!op.use_imm) begin
      rhs = right_source_gpr_i;
    end else if (op.is_signed) begin
      rhs = imm_sext;
    end else begin
      rhs = imm_zext;
    end
  end

  // ==========================================================
  // Full-width comparison
  logic is_eq;
  logic is_gt;

  sfc_cmp_core #(
    .WIDTH    (`SFC_XLEN)
  ) u_cmp (
    .lhs_i    (left_source_gpr_i),
    .rhs_i    (rhs),
    .signed_i (op.is_signed),
    .eq_o     (is_eq),
    .gt_o     (is_gt)
  );

  // ==========================================================
  // Condition evaluation; every compare either sets or clears
  logic cond_true;

  always_comb begin
    case (op.cond)
      sfc_pkg::COND_EQ: cond_true = is_eq;
      sfc_pkg::COND_GE: cond_true = is_gt | is_eq;
      sfc_pkg::COND_GT: cond_true = is_gt;
      sfc_pkg::COND_LE: cond_true = ~is_gt;
      default:          cond_true = 1'b0;
    endcase
  end

  logic fire;

  assign fire = instr_valid_i & op.hit;

  // ==========================================================
  // Result assembly
  sfc_pkg::cmp_res_s nxt_res;

  always_comb begin
    nxt_res         = '0;
    nxt_res.flag    = cond_true;
    nxt_res.wr      = fire;
    nxt_res.not_cmp = instr_valid_i & ~op.hit;
    // Reserved bits are only reported, never trapped
    nxt_res.rsv_nz  = fire & ~op.use_imm &
                      (rsv_bits != `SFC_RSV_ZERO);
  end

  // ==========================================================
  // Compare flag of the supervision register
  logic flag_ff;

  // A compare wins over a same-cycle load, since the compare is the
  // later instruction in program order
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_ff <= `SFC_FLAG_RST;
    end else if (fire) begin
      flag_ff <= nxt_res.flag;
    end else if (sr_flag_load_i) begin
      flag_ff <= sr_flag_val_i;
    end
  end

  // ==========================================================
  // Write-back strobes, one cycle after issue
  logic flag_wr_ff;
  logic not_cmp_ff;
  logic rsv_nz_ff;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      flag_wr_ff <= 1'b0;
      not_cmp_ff <= 1'b0;
      rsv_nz_ff  <= 1'b0;
    end else begin
      flag_wr_ff <= nxt_res.wr;
      not_cmp_ff <= nxt_res.not_cmp;
      rsv_nz_ff  <= nxt_res.rsv_nz;
    end
  end

  assign flag_o    = flag_ff;
  assign flag_wr_o = flag_wr_ff;
  assign not_cmp_o = not_cmp_ff;
  assign rsv_nz_o  = rsv_nz_ff;

endmodule

// ### hdl/sfc_map.svh
// Constants for the set-flag compare unit: field positions, opcodes,
// widths and reset values.
// Assumes a 32-bit instruction word and one core clock.
//
// Operation
// - Register form: 11-bit opcode, two 5-bit sources, 11 reserved bits.
// - Opcode 0x720 sets flag when both sources are equal, else clears.
// - Opcode 0x5e0 sets flag when source equals sign-extended immediate.
// - Opcode 0x72b: signed register greater-or-equal sets flag, else clears.
// - Opcode 0x5eb: signed greater-or-equal against sign-extended immediate.
// - Opcode 0x723: unsigned register greater-or-equal sets flag.
// - Opcode 0x5e3: unsigned greater-or-equal to zero-extended immediate.
// - Signed register greater-than sets flag only on strict excess.
// - Signed immediate greater-than, immediate sign-extended, strict excess.
// - Unsigned immediate greater-than, immediate zero-extended, strict.
// - Opcode 0x72d: signed register less-or-equal sets flag.
// - Signed immediate less-or-equal, immediate sign-extended.
// - Opcode 0x725: unsigned register less-or-equal sets flag.
// - Compare over the full register width of the implementation.
// - Unsigned immediate less-or-equal, immediate zero-extended.
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// ==========================================================
// Widths
`define SFC_XLEN        32
`define SFC_INSN_W      32
`define SFC_OPC_W       11
`define SFC_IDX_W       5
`define SFC_IMM_W       16
`define SFC_RSV_W       11

// ==========================================================
// Field positions
`define SFC_OPC_HI      31
`define SFC_OPC_LO      21
`define SFC_LEFT_HI     20
`define SFC_LEFT_LO     16
`define SFC_RIGHT_HI    15
`define SFC_RIGHT_LO    11
`define SFC_RSV_HI      10
`define SFC_RSV_LO      0
`define SFC_IMM_HI      15
`define SFC_IMM_LO      0

// ==========================================================
// Opcodes, register form
`define SFC_OP_EQ       11'h720
`define SFC_OP_GTU      11'h722
`define SFC_OP_GEU      11'h723
`define SFC_OP_LEU      11'h725
`define SFC_OP_GTS      11'h72a
`define SFC_OP_GES      11'h72b
`define SFC_OP_LES      11'h72d

// ==========================================================
// Opcodes, immediate form
`define SFC_OP_EQI      11'h5e0
`define SFC_OP_GTUI     11'h5e2
`define SFC_OP_GEUI     11'h5e3
`define SFC_OP_LEUI     11'h5e5
`define SFC_OP_GTSI     11'h5ea
`define SFC_OP_GESI     11'h5eb
`define SFC_OP_LESI     11'h5ed

// ==========================================================
// Reset values
`define SFC_FLAG_RST    1'h0
`define SFC_RSV_ZERO    11'h000

`endif

// ### hdl/sfc_pkg.sv
// Types shared by the set-flag compare unit.
// Assumes sfc_map.svh is on the include path.
`include "sfc_map.svh"

package sfc_pkg;

  // ==========================================================
  // Compare conditions
  typedef enum logic [1:0] {
    COND_EQ,
    COND_GE,
    COND_GT,
    COND_LE
  } cmp_cond_e;

  // ==========================================================
  // Decoded compare instruction
  typedef struct packed {
    logic      hit;
    cmp_cond_e cond;
    logic      is_signed;
    logic      use_imm;
  } cmp_op_s;

  // ==========================================================
  // Result handed to flag write-back
  typedef struct packed {
    logic flag;
    logic wr;
    logic not_cmp;
    logic rsv_nz;
  } cmp_res_s;

endpackage

// ### hdl/sfc_cmp_core.sv
// Magnitude and equality comparator, signed or unsigned.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/100ps

module sfc_cmp_core #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] lhs_i,
  input  wire logic [WIDTH-1:0] rhs_i,
  input  wire logic             signed_i,
  output logic                  eq_o,
  output logic                  gt_o
);

  logic [WIDTH-1:0] lhs_adj;
  logic [WIDTH-1:0] rhs_adj;

  // ==========================================================
  // Signed order equals unsigned order once the sign bits flip,
  // so one magnitude comparator serves both forms
  always_comb begin
    lhs_adj = lhs_i;
    rhs_adj = rhs_i;
    if (signed_i) begin
      lhs_adj[WIDTH-1] = ~lhs_i[WIDTH-1];
      rhs_adj[WIDTH-1] = ~rhs_i[WIDTH-1];
    end
  end

  assign eq_o = (lhs_i == rhs_i);
  assign gt_o = (lhs_adj > rhs_adj);

endmodule

// ### verif/sfc_props.sv
// Port-level checks for the set-flag compare unit.
// Assumes sfc_map.svh is on the include path; bound to the unit below.
`timescale 1ns/100ps
`include "sfc_map.svh"

module sfc_props (
  input wire logic                    mclk_i,
  input wire logic                    srst_i,
  input wire logic                    instr_valid_i,
  input wire logic [`SFC_INSN_W-1:0]  instr_i,
  input wire logic [`SFC_XLEN-1:0]    left_source_gpr_i,
  input wire logic [`SFC_XLEN-1:0]    right_source_gpr_i,
  input wire logic                    sr_flag_load_i,
  input wire logic                    sr_flag_val_i,
  input wire logic [`SFC_IDX_W-1:0]   left_idx_o,
  input wire logic [`SFC_IDX_W-1:0]   right_idx_o,
  input wire logic                    flag_o,
  input wire logic                    flag_wr_o,
  input wire logic                    not_cmp_o,
  input wire logic                    rsv_nz_o
);
  logic [`SFC_XLEN-1:0] l_v;
  logic [`SFC_XLEN-1:0] r_v;
  logic [`SFC_XLEN-1:0] imm_s;
  logic [`SFC_XLEN-1:0] imm_z;
  assign l_v   = left_source_gpr_i;
  assign r_v   = right_source_gpr_i;
  assign imm_s = {{16{instr_i[15]}}, instr_i[15:0]};
  assign imm_z = {16'h0000, instr_i[15:0]};

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  // ==========================================================
  // Issue then result
  sequence s_issue(logic [10:0] op);
    !srst_i && instr_valid_i && instr_i[31:21] == op;
  endsequence

  property p_eq;
    s_issue(`SFC_OP_EQ) |=> flag_wr_o && flag_o == $past(l_v == r_v);
  endproperty
  a_eq: assert property (p_eq)
    else $error("register equality flag wrong");
  property p_eqi;
    s_issue(`SFC_OP_EQI) |=> flag_o == $past(l_v == imm_s);
  endproperty
  a_eqi: assert property (p_eqi)
    else $error("immediate equality flag wrong");
  property p_ges;
    s_issue(`SFC_OP_GES) |=> flag_o == $past($signed(l_v) >= $signed(r_v));
  endproperty
  a_ges: assert property (p_ges)
    else $error("signed ge flag wrong");
  property p_geui;
    s_issue(`SFC_OP_GEUI) |=> flag_o == $past(l_v >= imm_z);
  endproperty
  a_geui: assert property (p_geui)
    else $error("unsigned ge immediate flag wrong");
  property p_gtu;
    s_issue(`SFC_OP_GTU) |=> flag_o == $past(l_v > r_v);
  endproperty
  a_gtu: assert property (p_gtu)
    else $error("unsigned gt flag wrong");
  property p_lesi;
    s_issue(`SFC_OP_LESI) |=>
      flag_o == $past($signed(l_v) <= $signed(imm_s));
  endproperty
  a_lesi: assert property (p_lesi)
    else $error("signed le immediate flag wrong");
  // Idle cycles must leave the flag alone for later readers
  property p_hold;
    !srst_i && !instr_valid_i && !sr_flag_load_i |=>
      $stable(flag_o) && !flag_wr_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag changed without cause");
  property p_idx;
    left_idx_o == instr_i[20:16] && right_idx_o == instr_i[15:11];
  endproperty
  a_idx: assert property (p_idx)
    else $error("source index fields wrong");
endmodule

bind set_flag_compare_unit sfc_props sfc_props_inst (
  .mclk_i(mclk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
  .instr_i(instr_i), .left_source_gpr_i(left_source_gpr_i),
  .right_source_gpr_i(right_source_gpr_i),
  .sr_flag_load_i(sr_flag_load_i), .sr_flag_val_i(sr_flag_val_i),
  .left_idx_o(left_idx_o), .right_idx_o(right_idx_o), .flag_o(flag_o),
  .flag_wr_o(flag_wr_o), .not_cmp_o(not_cmp_o), .rsv_nz_o(rsv_nz_o));

// ### verif/tb.sv
// Self-checking bench for the set-flag compare unit.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps

module tb;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        instr_valid_i = 1'b0;
  logic [31:0] instr_i = 32'h0000_0000;
  logic [31:0] left_source_gpr_i = 32'h0000_0000;
  logic [31:0] right_source_gpr_i = 32'h0000_0000;
  logic        sr_flag_load_i = 1'b0;
  logic        sr_flag_val_i = 1'b0;
  logic [4:0]  left_idx_o;
  logic [4:0]  right_idx_o;
  logic        flag_o;
  logic        flag_wr_o;
  logic        not_cmp_o;
  logic        rsv_nz_o;
  logic        m_flag, m_wr, m_nc, m_rsv;
  logic [1:0]  res;
  int          fails = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [10:0] ops [14] = '{11'h720, 11'h722, 11'h723, 11'h725, 11'h72a,
    11'h72b, 11'h72d, 11'h5e0, 11'h5e2, 11'h5e3, 11'h5e5, 11'h5ea, 11'h5eb,
    11'h5ed};

  always #10 mclk_i = ~mclk_i;

  set_flag_compare_unit set_flag_compare_unit_inst (
    .mclk_i(mclk_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .left_source_gpr_i(left_source_gpr_i),
    .right_source_gpr_i(right_source_gpr_i),
    .sr_flag_load_i(sr_flag_load_i), .sr_flag_val_i(sr_flag_val_i),
    .left_idx_o(left_idx_o), .right_idx_o(right_idx_o), .flag_o(flag_o),
    .flag_wr_o(flag_wr_o), .not_cmp_o(not_cmp_o), .rsv_nz_o(rsv_nz_o));

  // ==========================================================
  // Reference model: {recognised, flag}
  function automatic logic [1:0] model(logic [31:0] ins, logic [31:0] a,
                                       logic [31:0] b);
    logic [3:0] lo;
    longint     x;
    longint     y;
    lo = ins[24:21];
    x  = lo[3] ? longint'($signed(a)) : longint'(a);
    if (ins[31:25] == 7'h5e)
      y = (lo[3] || lo == 4'h0) ? longint'($signed(ins[15:0]))
                                : longint'(ins[15:0]);
    else
      y = lo[3] ? longint'($signed(b)) : longint'(b);
    case (lo)
      4'h0: model = {1'b1, x[31:0] == y[31:0]};
      4'h2, 4'ha: model = {1'b1, x > y};
      4'h3, 4'hb: model = {1'b1, x >= y};
      4'h5, 4'hd: model = {1'b1, x <= y};
      default: model = 2'b00;
    endcase
    if (ins[31:25] != 7'h5e && ins[31:25] != 7'h72)
      model = 2'b00;
  endfunction

  always @(posedge mclk_i) begin
    res = model(instr_i, left_source_gpr_i, right_source_gpr_i);
    if (srst_i) begin
      {m_flag, m_wr, m_nc, m_rsv} <= 4'h0;
    end else begin
      m_wr  <= instr_valid_i && res[1];
      m_nc  <= instr_valid_i && !res[1];
      m_rsv <= instr_valid_i && res[1] && instr_i[31:25] == 7'h72 &&
               instr_i[10:0] != 11'h000;
      // Compare outranks a flag load in the same cycle
      if (instr_valid_i && res[1]) m_flag <= res[0];
      else if (sr_flag_load_i) m_flag <= sr_flag_val_i;
    end
  end

  // ==========================================================
  // Checking and verdict
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(negedge mclk_i) begin
    if (cycles > 1) begin
      chk(flag_o, m_flag);
      chk(flag_wr_o, m_wr);
      chk(not_cmp_o, m_nc);
      chk(rsv_nz_o, m_rsv);
      chk(left_idx_o, instr_i[20:16]);
      chk(right_idx_o, instr_i[15:11]);
    end
  end

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================
  // Stimulus: all opcodes, near-equal operands, loads, stray opcodes
  task automatic drive(int i);
    logic [10:0] op;
    logic [15:0] imm;
    logic [31:0] t;
    logic [31:0] a;
    op  = ($urandom % 8 == 0) ? 11'($urandom) : ops[i % 14];
    imm = 16'($urandom);
    t   = $urandom;
    if ($urandom % 4 == 0) t[30:0] = 31'h0;
    if (op[10:4] == 7'h5e)
      t = (op[3] || op[2:0] == 3'h0) ? {{16{imm[15]}}, imm} : {16'h0, imm};
    case ($urandom % 4)
      0: a = t;
      1: a = t + 32'h0000_0001;
      2: a = t - 32'h0000_0001;
      default: a = $urandom;
    endcase
    // No instruction in the cycle in which reset is lifted
    instr_valid_i      <= ($urandom % 8 != 0) && (i != 1502);
    instr_i            <= (op[10:4] == 7'h5e) ? {op, 5'($urandom), imm} :
      {op, 10'($urandom), ($urandom % 2) ? 11'($urandom) : 11'h000};
    left_source_gpr_i  <= a;
    right_source_gpr_i <= (op[10:4] == 7'h5e) ? $urandom : t;
    sr_flag_load_i     <= ($urandom % 4 == 0);
    sr_flag_val_i      <= 1'($urandom);
  endtask

  initial begin
    void'($urandom(27));
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk_i);
      srst_i <= (i >= 1500 && i < 1502);
      drive(i);
    end
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    end_of_test();
  end
endmodule
